// ---- hw/host_port_pkg.sv ----
// Purpose: Shared constants and types for the parallel host byte port.
// Assumes: 25 MHz core clock; host pins are asynchronous to it.
// Notes: Offsets into the filtered pin vector are listed here once.

package host_port_pkg;

	// ***************************************************************
	// Widths and clock
	// ***************************************************************
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int CLK_PERIOD_PS = 40000;

	// Host must hold each strobe level this long; three-stage
	// sampling at 40 ns can miss such a short pulse
	localparam real HOST_PULSE_MIN_NS = 20.5;
	localparam int HOST_PULSE_MIN_CYC =
		(int'(HOST_PULSE_MIN_NS * 1000.0) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ***************************************************************
	// Filtered pin vector layout
	// ***************************************************************
	localparam int PIN_W = 15;
	localparam int PIN_SEL_N = 0;
	localparam int PIN_RD = 1;
	localparam int PIN_WR = 2;
	localparam int PIN_DS = 3;
	localparam int PIN_DIR = 4;
	localparam int PIN_STAT = 5;
	localparam int PIN_BSEL = 6;
	localparam int PIN_DATA = 7;
	localparam logic [PIN_W-1:0] PIN_RESET = 15'h0007;

	// ***************************************************************
	// Reset values and byte order
	// ***************************************************************
	localparam logic LAST_BYTE_SEL = 1'b0;
	localparam logic [BYTE_W-1:0] BUS_RESET = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic OBE_PIN_RESET = 1'b1;
	localparam logic IBF_PIN_RESET = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} frame_state_t;

endpackage

// ---- hw/pin_filter.sv ----
// Purpose: Three-stage sampler for asynchronous host pins.
// Assumes: Reset is already synchronous to the clock.
// Notes: A bit changes once the second and third stage agree.

`timescale 1ns/1ns

module pin_filter
	import host_port_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Pins
	input wire logic [PIN_W-1:0] pins_i,
	output logic [PIN_W-1:0] pins_o
);

	logic [PIN_W-1:0] meta_q;
	logic [PIN_W-1:0] mid_q;
	logic [PIN_W-1:0] late_q;
	logic [PIN_W-1:0] filt_q;
	logic [PIN_W-1:0] filt_d;

	// Only mid_q reads meta_q; the agreement test uses later stages
	for (genvar i = 0; i < PIN_W; i++)
	begin : g_bit
		always_comb
		begin
			filt_d[i] = (mid_q[i] == late_q[i]) ? late_q[i] : filt_q[i];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= PIN_RESET;
			mid_q <= PIN_RESET;
			late_q <= PIN_RESET;
			filt_q <= PIN_RESET;
		end
		else
		begin
			meta_q <= pins_i;
			mid_q <= meta_q;
			late_q <= mid_q;
			filt_q <= filt_d;
		end
	end

	assign pins_o = filt_q;

endmodule // pin_filter

// ---- hw/word_buffer.sv ----
// Purpose: One 16-bit buffer word with byte access and a full flag.
// Assumes: Word load and byte write never coincide.
// Notes: A set of the full flag wins over a clear in the same cycle.

`timescale 1ns/1ns

module word_buffer
	import host_port_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Whole-word load
	input wire logic load_word_i,
	input wire logic [WORD_W-1:0] word_i,
	// Single byte write
	input wire logic load_byte_i,
	input wire logic byte_sel_i,
	input wire logic [BYTE_W-1:0] byte_i,
	// Flag control
	input wire logic set_full_i,
	input wire logic clr_full_i,
	// State
	output logic [WORD_W-1:0] word_o,
	output logic full_o
);

	logic [WORD_W-1:0] word_q;
	logic [WORD_W-1:0] word_d;
	logic full_q;
	logic full_d;

	always_comb
	begin
		word_d = word_q;
		if (load_word_i)
			word_d = word_i;
		else if (load_byte_i && byte_sel_i)
			word_d[WORD_W-1:BYTE_W] = byte_i;
		else if (load_byte_i)
			word_d[BYTE_W-1:0] = byte_i;
		full_d = set_full_i ? 1'b1 : (clr_full_i ? 1'b0 : full_q);
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			word_q <= WORD_RESET;
			full_q <= 1'b0;
		end
		else
		begin
			word_q <= word_d;
			full_q <= full_d;
		end
	end

	assign word_o = word_q;
	assign full_o = full_q;

endmodule // word_buffer

// ---- hw/host_byte_port.sv ----
// Purpose: Transaction framing for the 8-bit parallel host byte port.
// Assumes: Host keeps selects and direction stable across a transaction.
// Notes: Pins are sampled, so edges are seen three to four clocks late.

`timescale 1ns/1ns

module host_byte_port
	import host_port_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	// Host framing pins
	input wire logic PORT_SELECT_N_I,
	input wire logic READ_STROBE_I,
	input wire logic WRITE_STROBE_I,
	input wire logic SHARED_DATA_STROBE_I,
	input wire logic DIRECTION_LINE_I,
	input wire logic STATUS_SELECT_I,
	input wire logic BYTE_SELECT_I,
	// Host byte bus
	input wire logic [host_port_pkg::BYTE_W-1:0] HOST_BYTE_BUS_I,
	output logic [host_port_pkg::BYTE_W-1:0] HOST_BYTE_BUS_O,
	output logic HOST_BYTE_BUS_OE_O,
	// Host flags
	output logic OUT_BUFFER_EMPTY_FLAG_O,
	output logic IN_BUFFER_FULL_FLAG_O,
	// Configuration
	input wire logic SINGLE_STROBE_MODE_I,
	input wire logic STROBE_ACTIVE_HIGH_I,
	input wire logic OBE_INVERT_I,
	input wire logic IBF_INVERT_I,
	// Core side
	input wire logic [host_port_pkg::WORD_W-1:0] CORE_OUT_WORD_I,
	input wire logic CORE_OUT_LOAD_I,
	output logic CORE_OUT_FULL_O,
	output logic [host_port_pkg::WORD_W-1:0] CORE_IN_WORD_O,
	output logic CORE_IN_FULL_O,
	input wire logic CORE_IN_TAKE_I
);

	// ***************************************************************
	// Reset release
	// ***************************************************************
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ***************************************************************
	// Pin sampling
	// ***************************************************************
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins;

	assign pins_raw = {HOST_BYTE_BUS_I, BYTE_SELECT_I, STATUS_SELECT_I, DIRECTION_LINE_I,
		SHARED_DATA_STROBE_I, WRITE_STROBE_I, READ_STROBE_I, PORT_SELECT_N_I};

	// Data is sampled with the same latency as the strobes so that the
	// byte seen at the ending edge is the one the host held there
	pin_filter u_pin_filter (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n_q),
		.pins_i(pins_raw),
		.pins_o(pins)
	);

	logic sel;
	logic rd_on;
	logic wr_on;
	logic ds_on;
	logic shared_on;
	logic [BYTE_W-1:0] bus_in;

	always_comb
	begin
		sel = !pins[PIN_SEL_N];
		rd_on = sel && !pins[PIN_RD];
		wr_on = sel && !pins[PIN_WR];
		ds_on = STROBE_ACTIVE_HIGH_I ? pins[PIN_DS] : !pins[PIN_DS];
		shared_on = sel && ds_on;
		bus_in = pins[PIN_DATA+BYTE_W-1:PIN_DATA];
	end

	// ***************************************************************
	// Transaction framing
	// ***************************************************************
	frame_state_t state_q;
	frame_state_t state_d;
	logic stat_q;
	logic stat_d;
	logic bsel_q;
	logic bsel_d;
	logic rd_end;
	logic wr_end;

	always_comb
	begin
		state_d = state_q;
		stat_d = stat_q;
		bsel_d = bsel_q;
		rd_end = 1'b0;
		wr_end = 1'b0;
		unique case (state_q)
			ST_IDLE:
			begin
				stat_d = pins[PIN_STAT];
				bsel_d = pins[PIN_BSEL];
				// Direction is looked at only as a frame opens
				if (SINGLE_STROBE_MODE_I && shared_on)
					state_d = pins[PIN_DIR] ? ST_READ : ST_WRITE;
				else if (!SINGLE_STROBE_MODE_I && rd_on)
					state_d = ST_READ;
				else if (!SINGLE_STROBE_MODE_I && wr_on)
					state_d = ST_WRITE;
			end
			ST_READ:
			begin
				// Direction edges do not close a frame
				if (SINGLE_STROBE_MODE_I ? !shared_on : !rd_on)
				begin
					state_d = ST_IDLE;
					rd_end = 1'b1;
				end
			end
			ST_WRITE:
			begin
				if (SINGLE_STROBE_MODE_I ? !shared_on : !wr_on)
				begin
					state_d = ST_IDLE;
					wr_end = 1'b1;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q <= ST_IDLE;
			stat_q <= 1'b0;
			bsel_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			stat_q <= stat_d;
			bsel_q <= bsel_d;
		end
	end

	// ***************************************************************
	// Buffers
	// ***************************************************************
	logic out_full;
	logic in_full;
	logic [WORD_W-1:0] out_word;
	logic host_rd_last;
	logic host_wr_data;
	logic host_wr_last;

	// Reading the last byte of a word empties the output buffer
	assign host_rd_last = rd_end && !stat_q && (bsel_q == LAST_BYTE_SEL);
	// Writes to the status select have nowhere to land and are dropped
	assign host_wr_data = wr_end && !stat_q;
	assign host_wr_last = host_wr_data && (bsel_q == LAST_BYTE_SEL);

	word_buffer u_out_buffer (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n_q),
		.load_word_i(CORE_OUT_LOAD_I),
		.word_i(CORE_OUT_WORD_I),
		.load_byte_i(1'b0),
		.byte_sel_i(1'b0),
		.byte_i(BUS_RESET),
		.set_full_i(CORE_OUT_LOAD_I),
		.clr_full_i(host_rd_last),
		.word_o(out_word),
		.full_o(out_full)
	);

	word_buffer u_in_buffer (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n_q),
		.load_word_i(1'b0),
		.word_i(WORD_RESET),
		.load_byte_i(host_wr_data),
		.byte_sel_i(bsel_q),
		.byte_i(bus_in),
		.set_full_i(host_wr_last),
		.clr_full_i(CORE_IN_TAKE_I),
		.word_o(CORE_IN_WORD_O),
		.full_o(in_full)
	);

	assign CORE_OUT_FULL_O = out_full;
	assign CORE_IN_FULL_O = in_full;

	// ***************************************************************
	// Pin outputs
	// ***************************************************************
	logic [BYTE_W-1:0] bus_q;
	logic [BYTE_W-1:0] bus_d;
	logic bus_oe_q;
	logic bus_oe_d;
	logic obe_q;
	logic obe_d;
	logic ibf_q;
	logic ibf_d;

	always_comb
	begin
		// Status read returns both raw buffer states
		if (stat_d)
			bus_d = {6'h00, in_full, !out_full};
		else if (bsel_d)
			bus_d = out_word[WORD_W-1:BYTE_W];
		else
			bus_d = out_word[BYTE_W-1:0];
		bus_oe_d = (state_d == ST_READ);
		obe_d = !out_full ^ OBE_INVERT_I;
		ibf_d = in_full ^ IBF_INVERT_I;
	end

	always_ff @(posedge CLOCK_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			bus_q <= BUS_RESET;
			bus_oe_q <= 1'b0;
			obe_q <= OBE_PIN_RESET;
			ibf_q <= IBF_PIN_RESET;
		end
		else
		begin
			bus_q <= bus_d;
			bus_oe_q <= bus_oe_d;
			obe_q <= obe_d;
			ibf_q <= ibf_d;
		end
	end

	assign HOST_BYTE_BUS_O = bus_q;
	assign HOST_BYTE_BUS_OE_O = bus_oe_q;
	assign OUT_BUFFER_EMPTY_FLAG_O = obe_q;
	assign IN_BUFFER_FULL_FLAG_O = ibf_q;

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!rst_n_q);

	chk_read_opens: assert property (
		state_q == ST_IDLE && !SINGLE_STROBE_MODE_I && rd_on |=> state_q == ST_READ)
		else $error("read not opened");
	chk_read_closes: assert property (
		state_q == ST_READ && !SINGLE_STROBE_MODE_I && !rd_on |=> state_q == ST_IDLE)
		else $error("read not closed");
	chk_write_opens: assert property (
		state_q == ST_IDLE && !SINGLE_STROBE_MODE_I && !rd_on && wr_on |=> state_q == ST_WRITE)
		else $error("write not opened");
	chk_write_closes: assert property (
		state_q == ST_WRITE && !SINGLE_STROBE_MODE_I && !wr_on |=> state_q == ST_IDLE)
		else $error("write not closed");
	chk_shared_frame: assert property (
		state_q == ST_IDLE && SINGLE_STROBE_MODE_I && shared_on
		|=> state_q == (pins[PIN_DIR] ? ST_READ : ST_WRITE))
		else $error("shared strobe frame wrong");
	chk_dir_ignored: assert property (
		state_q == ST_READ && SINGLE_STROBE_MODE_I && shared_on |=> state_q == ST_READ)
		else $error("direction closed a frame");
	chk_bus_drive: assert property (
		bus_oe_q |-> $past(SINGLE_STROBE_MODE_I ? shared_on : rd_on))
		else $error("bus driven outside a read");
	chk_obe_update: assert property (
		host_rd_last && !CORE_OUT_LOAD_I && $stable(OBE_INVERT_I)
		|=> !out_full ##1 obe_q == !OBE_INVERT_I)
		else $error("empty flag not updated");
	chk_ibf_update: assert property (
		host_wr_last && $stable(IBF_INVERT_I) |=> in_full ##1 ibf_q == !IBF_INVERT_I)
		else $error("full flag not updated");
	chk_byte_capture: assert property (
		host_wr_data && !bsel_q |=> CORE_IN_WORD_O[BYTE_W-1:0] == $past(bus_in))
		else $error("write byte lost");
	chk_reset_flags: assert property (
		$rose(rst_n_q) |-> obe_q == OBE_PIN_RESET && ibf_q == IBF_PIN_RESET)
		else $error("flags wrong after reset");

	cov_read: cover property (host_rd_last);
	cov_write: cover property (host_wr_last);
	cov_shared_read: cover property (SINGLE_STROBE_MODE_I && rd_end);
	cov_status: cover property (rd_end && stat_q);

endmodule // host_byte_port

// ---- sim/host_model.sv ----
// Purpose: Behavioural host that drives the byte port pins.
// Assumes: Pins change 1 ns after a rising clock edge.
// Notes: A released bus shows the inverse of its last value.

`timescale 1ns/1ns

module host_model
	import host_port_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Device side of the byte bus
	input wire logic [BYTE_W-1:0] dev_bus_i,
	input wire logic dev_oe_i,
	// Host pins
	output logic sel_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic ds_o,
	output logic dir_o,
	output logic stat_o,
	output logic bsel_o,
	output logic [BYTE_W-1:0] bus_o
);
	logic drv;
	logic [BYTE_W-1:0] wdata;
	logic [BYTE_W-1:0] last = 8'h00;

	// No pull on the bus, so a floating line must never look like held data
	assign bus_o = dev_oe_i ? dev_bus_i : (drv ? wdata : ~last);

	always @(posedge clk_i)
		last <= bus_o;

	initial
	begin
		sel_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		ds_o = 1'b1;
		dir_o = 1'b0;
		stat_o = 1'b0;
		bsel_o = 1'b0;
		drv = 1'b0;
		wdata = 8'h00;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic strobe(input logic single, input logic pol, input logic rd, input logic act);
		if (single)
			ds_o = act ? pol : ~pol;
		else if (rd)
			rd_n_o = ~act;
		else
			wr_n_o = ~act;
	endtask

	// One byte frame; strobe_last picks which pin goes active last and idle first
	task automatic xfer(input logic single, input logic pol, input logic rd, input logic stat,
		input logic bsel, input logic [BYTE_W-1:0] data, input logic strobe_last,
		output logic [BYTE_W-1:0] got);
		ds_o = ~pol;
		stat_o = stat;
		bsel_o = bsel;
		dir_o = rd;
		wdata = data;
		drv = ~rd;
		// Every level lasts at least three clocks, far above the minimum pulse width
		step(3);
		if (strobe_last)
			sel_n_o = 1'b0;
		else
			strobe(single, pol, rd, 1'b1);
		step(3);
		if (strobe_last)
			strobe(single, pol, rd, 1'b1);
		else
			sel_n_o = 1'b0;
		step(8);
		got = bus_o;
		if (strobe_last)
			strobe(single, pol, rd, 1'b0);
		else
			sel_n_o = 1'b1;
		step(3);
		sel_n_o = 1'b1;
		strobe(single, pol, rd, 1'b0);
		step(3);
		drv = 1'b0;
		step(4);
	endtask

	// Select held with the strobe idle while the direction line toggles
	task automatic wiggle(input logic pol);
		ds_o = ~pol;
		sel_n_o = 1'b0;
		step(3);
		repeat (3)
		begin
			dir_o = ~dir_o;
			step(3);
		end
		sel_n_o = 1'b1;
		step(4);
	endtask
endmodule // host_model

// ---- sim/tb_host_byte_port.sv ----
// Purpose: Self-checking bench for the host byte port.
// Assumes: Host pins come from host_model, core side from this bench.
// Notes: Flags are read once the frame has been idle for several clocks.

`timescale 1ns/1ns

module tb_host_byte_port;
	import host_port_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic single = 1'b0;
	logic pol = 1'b0;
	logic obe_inv = 1'b0;
	logic ibf_inv = 1'b0;
	logic [WORD_W-1:0] out_word = 16'h0000;
	logic out_load = 1'b0;
	logic in_take = 1'b0;
	logic sel_n, rd_n, wr_n, ds, dir, stat, bsel, oe, obe, ibf, out_full, in_full;
	logic [BYTE_W-1:0] bus_in;
	logic [BYTE_W-1:0] bus_out;
	logic [BYTE_W-1:0] got;
	logic [WORD_W-1:0] in_word;
	int n_fail = 0;
	int tests_run = 0;

	always #20 clk = ~clk;

	host_model host (.clk_i(clk), .dev_bus_i(bus_out), .dev_oe_i(oe), .sel_n_o(sel_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .ds_o(ds), .dir_o(dir), .stat_o(stat), .bsel_o(bsel), .bus_o(bus_in));

	host_byte_port uut (.CLOCK_I(clk), .RSTN_I(rst_n), .PORT_SELECT_N_I(sel_n), .READ_STROBE_I(rd_n),
		.WRITE_STROBE_I(wr_n), .SHARED_DATA_STROBE_I(ds), .DIRECTION_LINE_I(dir), .STATUS_SELECT_I(stat),
		.BYTE_SELECT_I(bsel), .HOST_BYTE_BUS_I(bus_in), .HOST_BYTE_BUS_O(bus_out), .HOST_BYTE_BUS_OE_O(oe),
		.OUT_BUFFER_EMPTY_FLAG_O(obe), .IN_BUFFER_FULL_FLAG_O(ibf), .SINGLE_STROBE_MODE_I(single),
		.STROBE_ACTIVE_HIGH_I(pol), .OBE_INVERT_I(obe_inv), .IBF_INVERT_I(ibf_inv),
		.CORE_OUT_WORD_I(out_word), .CORE_OUT_LOAD_I(out_load), .CORE_OUT_FULL_O(out_full),
		.CORE_IN_WORD_O(in_word), .CORE_IN_FULL_O(in_full), .CORE_IN_TAKE_I(in_take));

	// ***************************************************************
	// Helpers
	// ***************************************************************
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [WORD_W-1:0] act, input logic [WORD_W-1:0] exp);
		tests_run++;
		if (act !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, act, exp);
		end
	endtask

	task automatic chk_flag(input logic act, input logic exp);
		chk({15'h0000, act}, {15'h0000, exp});
	endtask

	task automatic chk_byte(input logic [BYTE_W-1:0] act, input logic [BYTE_W-1:0] exp);
		chk({8'h00, act}, {8'h00, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic load_core(input logic [WORD_W-1:0] w);
		out_word = w;
		out_load = 1'b1;
		tick(1);
		out_load = 1'b0;
		tick(3);
	endtask

	task automatic take_core();
		in_take = 1'b1;
		tick(1);
		in_take = 1'b0;
		tick(3);
	endtask

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_reset();
		chk_flag(oe, 1'b0);
		chk_flag(obe, 1'b1);
		chk_flag(ibf, 1'b0);
		chk_flag(in_full, 1'b0);
	endtask

	task automatic t_sep_read();
		load_core(16'ha5c3);
		chk_flag(obe, 1'b0);
		host.xfer(1'b0, pol, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1, got);
		chk_byte(got, 8'ha5);
		chk_flag(obe, 1'b0);
		chk_flag(oe, 1'b0);
		host.xfer(1'b0, pol, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, got);
		chk_byte(got, 8'hc3);
		chk_flag(obe, 1'b1);
		chk_flag(out_full, 1'b0);
	endtask

	task automatic t_sep_write();
		host.xfer(1'b0, pol, 1'b0, 1'b0, 1'b1, 8'h5a, 1'b0, got);
		chk_flag(ibf, 1'b0);
		host.xfer(1'b0, pol, 1'b0, 1'b0, 1'b0, 8'h96, 1'b1, got);
		chk(in_word, 16'h5a96);
		chk_flag(ibf, 1'b1);
		host.xfer(1'b0, pol, 1'b1, 1'b1, 1'b0, 8'h00, 1'b1, got);
		chk_byte(got, 8'h03);
		take_core();
		chk_flag(ibf, 1'b0);
	endtask

	// Each polarity moves its own data so a lost capture cannot hide
	task automatic t_single(input logic p);
		logic [BYTE_W-1:0] wbyte;
		wbyte = p ? 8'hc3 : 8'h3c;
		single = 1'b1;
		pol = p;
		tick(3);
		host.wiggle(p);
		chk_flag(oe, 1'b0);
		chk_flag(in_full, 1'b0);
		host.xfer(1'b1, p, 1'b0, 1'b0, 1'b0, wbyte, p, got);
		chk(in_word, {8'h5a, wbyte});
		chk_flag(ibf, 1'b1);
		take_core();
		load_core(p ? 16'h18e7 : 16'h7e81);
		host.xfer(1'b1, p, 1'b1, 1'b0, 1'b0, 8'h00, ~p, got);
		chk_byte(got, p ? 8'he7 : 8'h81);
		chk_flag(obe, 1'b1);
	endtask

	task automatic t_invert();
		single = 1'b0;
		obe_inv = 1'b1;
		ibf_inv = 1'b1;
		tick(4);
		chk_flag(obe, 1'b0);
		chk_flag(ibf, 1'b1);
		obe_inv = 1'b0;
		ibf_inv = 1'b0;
		tick(4);
		chk_flag(obe, 1'b1);
		chk_flag(ibf, 1'b0);
	endtask

	// ***************************************************************
	// Main sequence and hang guard
	// ***************************************************************
	initial
	begin
		tick(8);
		rst_n = 1'b1;
		tick(8);
		t_reset();
		t_sep_read();
		t_sep_write();
		t_single(1'b0);
		t_single(1'b1);
		t_invert();
		tally_and_finish();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("mismatch at %0t: run did not finish", $time);
		tally_and_finish();
	end
endmodule // tb_host_byte_port
